// *** shared/fsal_pkg.sv ***
/*
 * Shared constants and types for the field sampling and alert logic:
 * register indexes, field positions, reset values, timing tables and
 * the structs that carry sensor element data and conversion control.
 * Assumes a 250 MHz system clock and 32-bit AHB-Lite register access.
 */
`default_nettype none

package fsal_pkg;

    // ------------------------------------------------------------------
    // Clock and register map
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 250;
    localparam logic [7:0]  IDX_CHAN_CFG   = 8'h02;
    localparam logic [7:0]  IDX_ALERT_CFG  = 8'h03;
    localparam logic [7:0]  IDX_POWER      = 8'h27;
    localparam logic [7:0]  IDX_STATUS     = 8'h28;

    localparam logic [31:0] CHAN_CFG_RST   = 32'h000001C0;
    localparam logic [31:0] CHAN_CFG_WMASK = 32'h00F801E0;
    localparam logic [31:0] ALERT_CFG_RST  = 32'h00000000;
    localparam logic [31:0] ALERT_CFG_WMASK = 32'h07F3FFFF;
    localparam logic [31:0] POWER_RST      = 32'h00000000;
    localparam logic [31:0] POWER_WMASK    = 32'h00000073;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned POS_BW       = 21;
    localparam int unsigned POS_SCHEME   = 19;
    localparam int unsigned POS_AXIS_EN  = 6;
    localparam int unsigned POS_HOLD     = 5;
    localparam int unsigned POS_KIND     = 23;
    localparam int unsigned POS_NV_STAT  = 22;
    localparam int unsigned POS_NV_EN    = 21;
    localparam int unsigned POS_SIGNED   = 20;
    localparam int unsigned POS_ALERT_EN = 24;
    localparam int unsigned POS_LEVEL    = 0;
    localparam int unsigned POS_INACT    = 4;
    localparam int unsigned POS_MODE     = 0;
    localparam int unsigned POS_NEW_DATA = 7;
    localparam int unsigned POS_ALERT    = 6;
    localparam int unsigned POS_NV_BUSY  = 20;

    localparam logic [1:0] SCHEME_SUMMED = 2'h2;
    localparam logic [1:0] MODE_ACTIVE   = 2'h0;
    localparam logic [1:0] MODE_DUTY     = 2'h2;

    // ------------------------------------------------------------------
    // Timing tables, in microseconds
    // ------------------------------------------------------------------
    localparam int unsigned INACT_US [8] = '{500, 1000, 5000, 10000,
                                             50000, 100000, 500000, 1000000};
    // Rows by bandwidth code, columns by one, two or three axes.
    localparam int unsigned UPDATE_US [8][3] = '{
        '{160, 330, 495}, '{80, 170, 255}, '{40, 90, 135}, '{160, 330, 495},
        '{64, 138, 207},  '{32, 74, 111},  '{16, 42, 63},  '{160, 330, 495}};
    localparam int unsigned NO_AXIS_US = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SLEEP    = 2'b00,
        ST_CONVERT  = 2'b01,
        ST_EVAL     = 2'b10,
        ST_INACTIVE = 2'b11
    } fsal_state_t;

    typedef struct packed {
        logic [11:0] x_inner;
        logic [11:0] y_inner;
        logic [11:0] z_inner;
        logic [11:0] x_east;
        logic [11:0] x_west;
        logic [11:0] y_north;
        logic [11:0] y_south;
    } fsal_elems_t;

    typedef struct packed {
        logic       busy;
        logic [2:0] axis_en;
        logic       fir_en;
        logic [2:0] filter_rate_choice;
    } fsal_conv_t;

endpackage

`default_nettype wire

// *** rtl/fsal_core.sv ***
/*
 * Duty-cycled conversion sequencer, element scheme selection and field
 * alert detection with register access over AHB-Lite.
 * Assumes element samples are synchronous to clk_sys and valid whenever
 * a conversion ends, and that the nonvolatile store answers a log
 * request with a one-cycle acknowledge.
 */
`default_nettype none

module fsal_core
    import fsal_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = CLK_MHZ
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Sensor elements and conversion control
    input  wire fsal_elems_t elems,
    output fsal_conv_t       conv,
    output logic [35:0]      field_data,
    // Alert pin and nonvolatile log
    output logic             alert_n,
    output logic             nv_log_req,
    input  wire logic        nv_log_ack
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] chan_cfg;
    logic [31:0] alert_cfg;
    logic [31:0] power;
    logic        new_data;
    logic        alert;
    logic        ph_write;
    logic        ph_valid;
    logic [7:0]  ph_idx;
    logic        rd_status;

    fsal_state_t state;
    logic [31:0] cnt;
    logic [11:0] data_x;
    logic [11:0] data_y;
    logic [11:0] data_z;
    logic [11:0] ref_x;
    logic [11:0] ref_y;
    logic [11:0] ref_z;
    logic [1:0]  mode_prev;
    logic        cond;
    logic        cond_prev;

    logic [2:0]  bw;
    logic [1:0]  scheme;
    logic [2:0]  axis_en;
    logic        hold;
    logic        kind;
    logic        nv_en;
    logic        signed_en;
    logic [2:0]  alert_en;
    logic [1:0]  mode;
    logic [2:0]  inact_code;
    logic [1:0]  n_axes;
    logic [31:0] active_cycles;
    logic [31:0] inact_cycles;
    logic        addr_ok;
    logic        wr_en;
    logic [31:0] wdata;
    logic [2:0]  axis_hit;
    logic        next_cond;
    logic        conv_end;
    logic        inact_end;
    logic        clear_alert;
    logic [11:0] sel_x;
    logic [11:0] sel_y;
    logic [35:0] cur;
    logic [35:0] refs;

    assign bw         = chan_cfg[POS_BW +: 3];
    assign scheme     = chan_cfg[POS_SCHEME +: 2];
    assign axis_en    = chan_cfg[POS_AXIS_EN +: 3];
    assign hold       = chan_cfg[POS_HOLD];
    assign kind       = alert_cfg[POS_KIND];
    assign nv_en      = alert_cfg[POS_NV_EN];
    assign signed_en  = alert_cfg[POS_SIGNED];
    assign alert_en   = alert_cfg[POS_ALERT_EN +: 3];
    assign mode       = power[POS_MODE +: 2];
    assign inact_code = power[POS_INACT +: 3];

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    assign n_axes = 2'($countones(axis_en));
    always_comb begin
        if (n_axes == 2'h0) begin
            active_cycles = 32'(NO_AXIS_US * CYCLES_PER_US);
        end else begin
            active_cycles = 32'(UPDATE_US[bw][n_axes - 2'h1] * CYCLES_PER_US);
        end
    end
    assign inact_cycles = 32'(INACT_US[inact_code] * CYCLES_PER_US);
    assign conv_end     = (state == ST_CONVERT) && (cnt >= active_cycles - 32'h1);
    assign inact_end    = (state == ST_INACTIVE) && (cnt >= inact_cycles - 32'h1);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Zero wait states: a read returns the value at its address phase,
    // so a read directly behind a write to the same word sees old data.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign wr_en     = ph_valid && ph_write;
    assign wdata     = hwdata;
    assign clear_alert = wr_en && (ph_idx == IDX_STATUS) && wdata[POS_ALERT];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_idx   <= 8'h00;
        end else begin
            ph_valid <= hsel && hready && htrans[1];
            ph_write <= hwrite;
            ph_idx   <= addr_ok ? haddr[9:2] : 8'hFF;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hrdata    <= 32'h00000000;
            rd_status <= 1'b0;
        end else begin
            rd_status <= 1'b0;
            if (hsel && hready && htrans[1] && !hwrite) begin
                if (addr_ok && haddr[9:2] == IDX_CHAN_CFG) begin
                    hrdata <= chan_cfg;
                end else if (addr_ok && haddr[9:2] == IDX_ALERT_CFG) begin
                    hrdata <= alert_cfg;
                end else if (addr_ok && haddr[9:2] == IDX_POWER) begin
                    hrdata <= power;
                end else if (addr_ok && haddr[9:2] == IDX_STATUS) begin
                    hrdata    <= 32'h0 | (32'(new_data) << POS_NEW_DATA)
                               | (32'(alert) << POS_ALERT) | (32'(nv_log_req) << POS_NV_BUSY);
                    rd_status <= 1'b1;
                end else begin
                    hrdata <= 32'h00000000;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chan_cfg <= CHAN_CFG_RST;
            power    <= POWER_RST;
        end else if (wr_en && ph_idx == IDX_CHAN_CFG) begin
            chan_cfg <= wdata & CHAN_CFG_WMASK;
        end else if (wr_en && ph_idx == IDX_POWER) begin
            power <= wdata & POWER_WMASK;
        end
    end

    // The logged flag is set by the store acknowledge; set wins a write.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alert_cfg <= ALERT_CFG_RST;
        end else begin
            if (wr_en && ph_idx == IDX_ALERT_CFG) begin
                alert_cfg <= wdata & ALERT_CFG_WMASK;
            end
            if (nv_log_req && nv_log_ack) begin
                alert_cfg[POS_NV_STAT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_SLEEP;
            cnt   <= 32'h0;
        end else begin
            cnt <= cnt + 32'h1;
            case (state)
                ST_SLEEP: begin
                    cnt <= 32'h0;
                    if (mode == MODE_ACTIVE || mode == MODE_DUTY) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (mode != MODE_ACTIVE && mode != MODE_DUTY) begin
                        state <= ST_SLEEP;
                    end else if (conv_end) begin
                        state <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    cnt <= 32'h0;
                    if (mode == MODE_DUTY) begin
                        state <= ST_INACTIVE;
                    end else if (mode == MODE_ACTIVE) begin
                        state <= ST_CONVERT;
                    end else begin
                        state <= ST_SLEEP;
                    end
                end
                ST_INACTIVE: begin
                    if (mode != MODE_DUTY) begin
                        state <= ST_SLEEP;
                        cnt   <= 32'h0;
                    end else if (inact_end) begin
                        state <= ST_CONVERT;
                        cnt   <= 32'h0;
                    end
                end
                default: state <= ST_SLEEP;
            endcase
        end
    end

    assign conv.busy               = (state == ST_CONVERT);
    assign conv.axis_en            = axis_en;
    assign conv.fir_en             = (bw == 3'h0) || (bw == 3'h1) || (bw == 3'h2);
    assign conv.filter_rate_choice = bw;

    // ------------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------------
    // Reserved scheme code 1 falls back to the inner elements.
    assign sel_x = (scheme == SCHEME_SUMMED) ? 12'(elems.x_east + elems.x_west)
                                             : elems.x_inner;
    assign sel_y = (scheme == SCHEME_SUMMED) ? 12'(elems.y_north + elems.y_south)
                                             : elems.y_inner;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_x <= 12'h000;
            data_y <= 12'h000;
            data_z <= 12'h000;
        end else if (conv_end) begin
            if (axis_en[0]) data_x <= sel_x;
            if (axis_en[1]) data_y <= sel_y;
            if (axis_en[2]) data_z <= elems.z_inner;
        end
    end
    assign field_data = {data_z, data_y, data_x};

    // Reference is the last sample held when duty-cycled mode is entered.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_prev <= POWER_RST[1:0];
            ref_x     <= 12'h000;
            ref_y     <= 12'h000;
            ref_z     <= 12'h000;
        end else begin
            mode_prev <= mode;
            if (mode == MODE_DUTY && mode_prev != MODE_DUTY) begin
                ref_x <= data_x;
                ref_y <= data_y;
                ref_z <= data_z;
            end
        end
    end

    // ------------------------------------------------------------------
    // Alert detection
    // ------------------------------------------------------------------
    function automatic logic level_hit(input logic signed [13:0] v,
                                       input logic [5:0] t,
                                       input logic sgn);
        logic signed [13:0] sthr;
        logic [13:0]        mag;
        sthr = {{2{t[5]}}, t, 6'h00} + (t[5] ? 14'sh0040 : 14'sh003F);
        mag  = v[13] ? 14'(-v) : v;
        if (!sgn) begin
            level_hit = mag >= {3'h0, t, 5'h1F};
        end else if (t[5]) begin
            level_hit = v <= sthr;
        end else begin
            level_hit = v >= sthr;
        end
    endfunction

    assign cur  = field_data;
    assign refs = {ref_z, ref_y, ref_x};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic signed [13:0] v;
            always_comb begin
                if (kind) begin
                    v = {{2{cur[12*g+11]}}, cur[12*g +: 12]}
                      - {{2{refs[12*g+11]}}, refs[12*g +: 12]};
                end else begin
                    v = {{2{cur[12*g+11]}}, cur[12*g +: 12]};
                end
            end
            assign axis_hit[g] = axis_en[g] && alert_en[g]
                               && level_hit(v, alert_cfg[POS_LEVEL + 6*g +: 6], signed_en);
        end
    endgenerate

    // Delta compares only on wakes in duty-cycled mode.
    assign next_cond = (|axis_hit) && (!kind || mode == MODE_DUTY);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cond      <= 1'b0;
            cond_prev <= 1'b0;
        end else begin
            cond_prev <= cond;
            if (state == ST_EVAL) begin
                cond <= next_cond;
            end else if (mode != MODE_ACTIVE && mode != MODE_DUTY) begin
                cond <= 1'b0;
            end
        end
    end

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alert <= 1'b0;
        end else if (!hold) begin
            alert <= cond;
        end else if (cond) begin
            alert <= 1'b1;
        end else if (clear_alert) begin
            alert <= 1'b0;
        end
    end
    assign alert_n = ~alert;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            new_data <= 1'b0;
        end else if (state == ST_EVAL) begin
            new_data <= 1'b1;
        end else if (rd_status) begin
            new_data <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nv_log_req <= 1'b0;
        end else if (nv_en && cond && !cond_prev) begin
            nv_log_req <= 1'b1;
        end else if (nv_log_ack) begin
            nv_log_req <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** verif/fsal_nv_model.sv ***
/*
 * Nonvolatile store model: acknowledges each alert log request after a
 * lag that the bench chooses. Assumes the core holds its request until
 * it sees the one-cycle acknowledge.
 */
`default_nettype none

module fsal_nv_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Log handshake
    input  wire logic       nv_log_req,
    input  wire logic [3:0] lag,
    output logic            nv_log_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt;

    // The ack is dropped at once so that one request never earns two.
    always_ff @(posedge clk_sys) begin
        if (srst || !nv_log_req || nv_log_ack) begin
            wait_cnt   <= 4'h0;
            nv_log_ack <= 1'b0;
        end else if (wait_cnt == lag) begin
            nv_log_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

`default_nettype wire

// *** verif/fsal_checker.sv ***
/*
 * Concurrent checks on the ports of fsal_core.
 * Assumes it is bound into every fsal_core instance.
 */
`default_nettype none

module fsal_checker
    import fsal_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = CLK_MHZ
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // Register bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Conversion, alert and log
    input wire fsal_conv_t  conv,
    input wire logic [35:0] field_data,
    input wire logic        alert_n,
    input wire logic        nv_log_req,
    input wire logic        nv_log_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    int unsigned run;
    logic        cut;

    // Runs that a write may have cut short are not timed.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cut <= 1'b0;
        end else if (hsel && hready && htrans[1] && hwrite) begin
            cut <= 1'b1;
        end else if (!conv.busy) begin
            cut <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !conv.busy) begin
            run <= 0;
        end else begin
            run <= run + 1;
        end
    end

    function automatic int unsigned conv_len(logic [2:0] code, logic [2:0] en);
        int unsigned n;
        n = int'(en[0]) + int'(en[1]) + int'(en[2]);
        if (n == 0) begin
            return NO_AXIS_US * CYCLES_PER_US;
        end
        return UPDATE_US[code][n - 1] * CYCLES_PER_US;
    endfunction

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_fir_select: assert property (conv.fir_en == (conv.filter_rate_choice <= 3'h2))
        else $error("filter enable wrong for rate code");
    a_conv_length: assert property ($fell(conv.busy) && !cut |->
        run == conv_len($past(conv.filter_rate_choice), $past(conv.axis_en)))
        else $error("conversion length wrong");
    a_data_at_end: assert property ($changed(field_data) |->
        $past(conv.busy) || $past(conv.busy, 2))
        else $error("field data changed outside conversion end");
    a_read_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
        |-> $stable(hrdata))
        else $error("read data moved without a read");
    a_log_hold: assert property (nv_log_req && !nv_log_ack |=> nv_log_req)
        else $error("log request dropped before ack");
    a_log_clear: assert property (nv_log_req && nv_log_ack |=> !nv_log_req)
        else $error("log request held after ack");
    a_log_alert: assert property ($rose(nv_log_req) |-> ##[0:2] !alert_n)
        else $error("log request without alert");
endmodule

bind fsal_core fsal_checker #(.CYCLES_PER_US(CYCLES_PER_US)) u_chk (.*);

`default_nettype wire

// *** verif/fsal_core_test.sv ***
/*
 * Self-checking bench for fsal_core over AHB-Lite.
 * Assumes the checker is bound and CYCLES_PER_US is set to 1.
 */
`default_nettype none

module fsal_core_test
    import fsal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned CPU = 1;
    localparam logic [2:0]  CODES [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    localparam logic [11:0] XS [4] = '{12'h03F, 12'h03E, 12'hFC1, 12'hFC2};

    logic        clk_sys, srst, hsel, hwrite, hreadyout, hresp;
    logic        alert_n, nv_log_req, nv_log_ack;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [35:0] field_data;
    logic [3:0]  lag;
    fsal_elems_t elems;
    fsal_conv_t  conv;
    int          n_errors, n_checks, n;

    fsal_core #(.CYCLES_PER_US(CPU)) uut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .elems(elems), .conv(conv), .field_data(field_data), .alert_n(alert_n),
        .nv_log_req(nv_log_req), .nv_log_ack(nv_log_ack));
    fsal_nv_model nv (.clk_sys(clk_sys), .srst(srst), .nv_log_req(nv_log_req), .lag(lag),
        .nv_log_ack(nv_log_ack));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic close_out;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic run_len(input logic lvl);
        while (conv.busy === lvl) @(posedge clk_sys);
        while (conv.busy !== lvl) @(posedge clk_sys);
        n = 0;
        while (conv.busy === lvl) begin
            n++;
            @(posedge clk_sys);
        end
    endtask

    function automatic logic [31:0] chan(logic [2:0] c, logic [1:0] s, logic [2:0] e, logic h);
        return {8'h00, c, s, 10'h000, e, h, 5'h00};
    endfunction

    function automatic logic [31:0] alrt(logic [2:0] e, logic k, logic lg, logic [5:0] lv);
        return {5'h00, e, k, 1'b0, lg, 15'h0000, lv};
    endfunction

    // Settings change only while asleep, so no conversion straddles them.
    task automatic setup(input logic [31:0] c, input logic [31:0] a, input logic [31:0] p);
        bus(1'b1, IDX_POWER, 32'h00000001);
        repeat (600) @(posedge clk_sys);
        chk(36'(conv.busy), 36'h0);
        bus(1'b1, IDX_CHAN_CFG, c);
        bus(1'b1, IDX_ALERT_CFG, a);
        bus(1'b1, IDX_POWER, p);
    endtask

    task automatic chk_alert(input logic a);
        repeat (2) run_len(1'b1);
        chk(36'(alert_n), 36'(!a));
        bus(1'b0, IDX_STATUS, 32'h0);
        chk(36'(rd[POS_ALERT]), 36'(a));
    endtask

    task automatic put_x(input logic [11:0] x);
        @(posedge clk_sys);
        elems.x_inner <= x;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        bus(1'b0, IDX_CHAN_CFG, 32'h0);
        chk(36'(rd), 36'(CHAN_CFG_RST));
        bus(1'b0, IDX_ALERT_CFG, 32'h0);
        chk(36'(rd), 36'(ALERT_CFG_RST));
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(36'(rd), 36'h0);
    endtask

    task automatic t_timing;
        for (int i = 0; i < 6; i++) begin
            setup(chan(CODES[i], 2'h0, 3'h7, 1'b0), 32'h0, 32'h0);
            run_len(1'b1);
            chk(36'(n), 36'(UPDATE_US[CODES[i]][2] * CPU));
            chk(36'(conv.fir_en), 36'(CODES[i] < 3'h3));
        end
        for (int k = 0; k < 2; k++) begin
            setup(chan(3'h0, 2'h0, k ? 3'h3 : 3'h1, 1'b0), 32'h0, 32'h0);
            run_len(1'b1);
            chk(36'(n), 36'(UPDATE_US[0][k] * CPU));
            run_len(1'b0);
            chk(36'(n), 36'h1);
        end
    endtask

    task automatic t_duty;
        for (int k = 0; k < 2; k++) begin
            setup(chan(3'h6, 2'h0, 3'h1, 1'b0), 32'h0, {25'h0, 3'(k), 4'h2});
            run_len(1'b0);
            chk(36'(n), 36'(1 + INACT_US[k] * CPU));
        end
    endtask

    task automatic t_scheme;
        elems <= '{12'h123, 12'h456, 12'h789, 12'h7F0, 12'h020, 12'h100, 12'h0FF};
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), 32'h0, 32'h0);
        repeat (2) run_len(1'b1);
        chk(field_data, 36'h789456123);
        setup(chan(3'h6, 2'h2, 3'h7, 1'b0), 32'h0, 32'h0);
        repeat (2) run_len(1'b1);
        chk(field_data, 36'h7891FF810);
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), 32'h0, 32'h1);
        put_x(12'h555);
        repeat (600) @(posedge clk_sys);
        chk(field_data, 36'h7891FF810);
    endtask

    task automatic t_threshold;
        elems.y_inner <= 12'h7FF;
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), alrt(3'h1, 1'b0, 1'b0, 6'h01), 32'h0);
        for (int i = 0; i < 4; i++) begin
            put_x(XS[i]);
            chk_alert(i % 2 == 0);
        end
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), alrt(3'h1, 1'b0, 1'b0, 6'h01) | 32'h00100000, 32'h0);
        put_x(12'h07F);
        chk_alert(1'b1);
        put_x(12'hF81);
        chk_alert(1'b0);
    endtask

    task automatic t_hold;
        setup(chan(3'h6, 2'h0, 3'h7, 1'b1), alrt(3'h1, 1'b0, 1'b0, 6'h01), 32'h0);
        put_x(12'h03F);
        chk_alert(1'b1);
        put_x(12'h000);
        chk_alert(1'b1);
        bus(1'b1, IDX_STATUS, 32'h00000040);
        chk_alert(1'b0);
    endtask

    task automatic t_log;
        lag <= 4'h0;
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), alrt(3'h1, 1'b0, 1'b1, 6'h01), 32'h0);
        put_x(12'h03F);
        chk_alert(1'b1);
        bus(1'b0, IDX_ALERT_CFG, 32'h0);
        chk(36'(rd[POS_NV_STAT]), 36'h1);
        bus(1'b1, IDX_ALERT_CFG, alrt(3'h1, 1'b0, 1'b1, 6'h01));
        put_x(12'h000);
        chk_alert(1'b0);
        lag <= 4'h7;
        put_x(12'h03F);
        chk_alert(1'b1);
        bus(1'b0, IDX_ALERT_CFG, 32'h0);
        chk(36'(rd[POS_NV_STAT]), 36'h1);
    endtask

    task automatic t_delta;
        put_x(12'h3E8);
        setup(chan(3'h6, 2'h0, 3'h7, 1'b0), alrt(3'h1, 1'b1, 1'b0, 6'h05), 32'h0);
        chk_alert(1'b0);
        bus(1'b1, IDX_POWER, 32'h00000002);
        chk_alert(1'b0);
        put_x(12'h4B0);
        chk_alert(1'b1);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        {srst, hsel, hwrite, htrans, haddr, hwdata, lag} = '0;
        srst = 1'b1;
        elems = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_timing();
        t_duty();
        t_scheme();
        t_threshold();
        t_hold();
        t_log();
        t_delta();
        close_out();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end
endmodule

`default_nettype wire
